// File: shared/rsd_pkg.sv
// Purpose: constants, types and slot decoding for the register space decoder
// Assumes: 4-Kbyte register block split into 64 slots of 64 bytes
// Notes: slot maps are plain defaults; adjust to the module set that is built in
package rsd_pkg;

    // bus widths
    localparam int RSD_AW = 24;
    localparam int RSD_DW = 16;
    localparam int RSD_VOW = 10;

    // block placement: addr[23:20] = {map bit, 111}, addr[19:12] all ones
    localparam logic [2:0] RSD_BLK_HI_LOW3 = 3'h7;
    localparam logic [7:0] RSD_BLK_MID = 8'hFF;
    localparam int RSD_SLOT_LSB = 6;
    localparam int RSD_SLOT_W = 6;

    // slot maps, one bit per 64-byte slot
    localparam logic [63:0] RSD_IMPL_MAP = 64'hFFFF_0000_0000_FF0F;
    localparam logic [63:0] RSD_RSVD_MAP = 64'h0000_FFFF_0000_0000;
    localparam logic [63:0] RSD_SUPV_MAP = 64'h0000_0000_0000_0F03;

    // space type codes
    localparam logic [2:0] RSD_FC_SUP_DATA = 3'h5;
    localparam logic [2:0] RSD_FC_SUP_PROG = 3'h6;
    localparam int RSD_FC_SUP_BIT = 2;

    // fixed address of the reset vector fetch
    localparam logic [23:0] RSD_RESET_VEC_ADDR = 24'h00_0000;

    // reset values
    localparam logic [23:0] RSD_ADDR_RST = 24'h00_0000;
    localparam logic [15:0] RSD_DATA_RST = 16'h0000;
    localparam logic [2:0] RSD_FC_RST = 3'h0;

    typedef enum logic [1:0] {
        RSD_IDLE = 2'b00,
        RSD_ACT = 2'b01,
        RSD_END = 2'b11
    } rsd_state_t;

    // pick the bit of a slot map that covers an address
    function automatic logic rsd_slot_bit(input logic [63:0] map, input logic [23:0] addr);
        rsd_slot_bit = map[addr[RSD_SLOT_LSB +: RSD_SLOT_W]];
    endfunction : rsd_slot_bit

endpackage : rsd_pkg

// File: hw/rsd_region_decode.sv
// Purpose: classify one address against the module register block
// Assumes: inputs stable for the cycle in which the result is sampled
// Notes: purely combinational; reserved slots win over implemented ones
`timescale 1ns/1ns
`default_nettype none
module rsd_region_decode (
    input wire logic [23:0] addr_i,
    input wire logic module_map_select_i,
    output logic blk_o,
    output logic impl_o,
    output logic rsvd_o,
    output logic sup_only_o
);
    logic hi_hit;
    logic raw_impl;

    // block base follows the map bit
    assign hi_hit = (addr_i[23:20] == {module_map_select_i, rsd_pkg::RSD_BLK_HI_LOW3});
    assign blk_o = hi_hit && (addr_i[19:12] == rsd_pkg::RSD_BLK_MID);

    // slot lookups inside the block
    assign raw_impl = rsd_pkg::rsd_slot_bit(rsd_pkg::RSD_IMPL_MAP, addr_i);
    assign rsvd_o = blk_o && rsd_pkg::rsd_slot_bit(rsd_pkg::RSD_RSVD_MAP, addr_i);
    assign impl_o = blk_o && raw_impl && !rsvd_o;
    assign sup_only_o = impl_o && rsd_pkg::rsd_slot_bit(rsd_pkg::RSD_SUPV_MAP, addr_i);
endmodule : rsd_region_decode
`default_nettype wire

// File: hw/rsd_space_decoder.sv
// Purpose: address space decoder for the intermodule bus
// Assumes: core signals share mclk_i; the map bit comes from the integration config register
// Notes: one decision per address strobe, held until the strobe rises
`timescale 1ns/1ns
`default_nettype none
module rsd_space_decoder (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic addr_strobe_n_i,
    input wire logic [23:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic [2:0] space_type_code_i,
    input wire logic module_map_select_i,
    input wire logic vec_req_i,
    input wire logic vec_reset_i,
    input wire logic [9:0] vec_offset_i,
    input wire logic [23:0] vector_base_register_i,
    output logic int_sel_o,
    output logic ext_cycle_o,
    output logic rsvd_hit_o,
    output logic access_deny_o,
    output logic [5:0] reg_slot_o,
    output logic [23:0] ext_addr_o,
    output logic [15:0] ext_data_o,
    output logic [2:0] ext_fc_o,
    output logic vec_valid_o,
    output logic [23:0] vec_addr_o,
    output logic [2:0] vec_fc_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!reset_n_i);

    rsd_pkg::rsd_state_t state_reg, state_next;
    logic int_sel_reg, int_sel_next;
    logic ext_cycle_reg, ext_cycle_next;
    logic rsvd_reg, rsvd_next;
    logic deny_reg, deny_next;
    logic [5:0] slot_reg, slot_next;
    logic [23:0] addr_reg, addr_next;
    logic [15:0] data_reg, data_next;
    logic [2:0] fc_reg, fc_next;
    logic map_reg, map_next;
    logic vec_valid_reg, vec_valid_next;
    logic [23:0] vec_addr_reg, vec_addr_next;
    logic [2:0] vec_fc_reg, vec_fc_next;
    logic blk;
    logic impl;
    logic rsvd;
    logic sup_only;
    logic is_super;
    logic start;

    rsd_region_decode u_region (
        .addr_i(addr_i),
        .module_map_select_i(module_map_select_i),
        .blk_o(blk),
        .impl_o(impl),
        .rsvd_o(rsvd),
        .sup_only_o(sup_only)
    );

    assign is_super = space_type_code_i[rsd_pkg::RSD_FC_SUP_BIT];
    assign start = (state_reg == rsd_pkg::RSD_IDLE) && !addr_strobe_n_i;

    // cycle sequencing and selection decisions
    always_comb begin
        state_next = state_reg;
        int_sel_next = int_sel_reg;
        ext_cycle_next = ext_cycle_reg;
        rsvd_next = rsvd_reg;
        deny_next = deny_reg;
        slot_next = slot_reg;
        addr_next = addr_reg;
        data_next = data_reg;
        fc_next = fc_reg;
        map_next = map_reg;
        case (state_reg)
            rsd_pkg::RSD_IDLE: begin
                if (!addr_strobe_n_i) begin
                    state_next = rsd_pkg::RSD_ACT;
                    addr_next = addr_i;
                    data_next = wdata_i;
                    fc_next = space_type_code_i;
                    map_next = module_map_select_i;
                    slot_next = addr_i[rsd_pkg::RSD_SLOT_LSB +: rsd_pkg::RSD_SLOT_W];
                    int_sel_next = impl && !(sup_only && !is_super);
                    ext_cycle_next = !blk || (!impl && !rsvd);
                    rsvd_next = rsvd;
                    deny_next = sup_only && !is_super;
                end
            end
            rsd_pkg::RSD_ACT: begin
                if (addr_strobe_n_i) begin
                    state_next = rsd_pkg::RSD_END;
                    int_sel_next = 1'b0;
                    ext_cycle_next = 1'b0;
                    rsvd_next = 1'b0;
                    deny_next = 1'b0;
                end
            end
            rsd_pkg::RSD_END: begin
                state_next = rsd_pkg::RSD_IDLE;
            end
            default: begin
                state_next = rsd_pkg::RSD_IDLE;
                int_sel_next = 1'b0;
                ext_cycle_next = 1'b0;
                rsvd_next = 1'b0;
                deny_next = 1'b0;
            end
        endcase
    end

    // decision registers
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            state_reg <= rsd_pkg::RSD_IDLE;
            int_sel_reg <= 1'b0;
            ext_cycle_reg <= 1'b0;
            rsvd_reg <= 1'b0;
            deny_reg <= 1'b0;
            slot_reg <= 6'h00;
            addr_reg <= rsd_pkg::RSD_ADDR_RST;
            data_reg <= rsd_pkg::RSD_DATA_RST;
            fc_reg <= rsd_pkg::RSD_FC_RST;
            map_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            int_sel_reg <= int_sel_next;
            ext_cycle_reg <= ext_cycle_next;
            rsvd_reg <= rsvd_next;
            deny_reg <= deny_next;
            slot_reg <= slot_next;
            addr_reg <= addr_next;
            data_reg <= data_next;
            fc_reg <= fc_next;
            map_reg <= map_next;
        end
    end

    // vector fetch address and space
    always_comb begin
        vec_valid_next = vec_req_i;
        vec_addr_next = vec_addr_reg;
        vec_fc_next = vec_fc_reg;
        if (vec_req_i) begin
            if (vec_reset_i) begin
                vec_addr_next = rsd_pkg::RSD_RESET_VEC_ADDR;
                vec_fc_next = rsd_pkg::RSD_FC_SUP_PROG;
            end else begin
                vec_addr_next = 24'(vector_base_register_i + {14'h0000, vec_offset_i});
                vec_fc_next = rsd_pkg::RSD_FC_SUP_DATA;
            end
        end
    end

    // vector registers
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            vec_valid_reg <= 1'b0;
            vec_addr_reg <= rsd_pkg::RSD_ADDR_RST;
            vec_fc_reg <= rsd_pkg::RSD_FC_RST;
        end else begin
            vec_valid_reg <= vec_valid_next;
            vec_addr_reg <= vec_addr_next;
            vec_fc_reg <= vec_fc_next;
        end
    end

    // outputs straight from flops
    assign int_sel_o = int_sel_reg;
    assign ext_cycle_o = ext_cycle_reg;
    assign rsvd_hit_o = rsvd_reg;
    assign access_deny_o = deny_reg;
    assign reg_slot_o = slot_reg;
    assign ext_addr_o = addr_reg;
    assign ext_data_o = data_reg;
    assign ext_fc_o = fc_reg;
    assign vec_valid_o = vec_valid_reg;
    assign vec_addr_o = vec_addr_reg;
    assign vec_fc_o = vec_fc_reg;

    // checks on the decisions
    block_base_a: assert property (int_sel_o |-> ext_addr_o[23:20] == {map_reg, 3'h7})
        else $error("internal select outside mapped block base");
    bus_capture_a: assert property (start |=> ext_addr_o == $past(addr_i)
        && ext_data_o == $past(wdata_i))
        else $error("address or data not captured at strobe");
    unused_ext_a: assert property (start && blk && !impl && !rsvd |=> ext_cycle_o
        && !int_sel_o)
        else $error("unused block address not sent external");
    rsvd_no_ext_a: assert property (rsvd_hit_o |-> !ext_cycle_o && !int_sel_o)
        else $error("reserved range reached the external bus");
    user_deny_a: assert property (start && sup_only && !is_super |=> access_deny_o
        && !int_sel_o && !ext_cycle_o)
        else $error("user access to supervisor register not denied");
    super_ok_a: assert property (start && impl && is_super |=> int_sel_o && !access_deny_o)
        else $error("supervisor access to register refused");
    vec_space_a: assert property (vec_req_i |=> vec_valid_o
        && vec_fc_o == ($past(vec_reset_i) ? 3'h6 : 3'h5))
        else $error("vector fetch in wrong space");
    vec_sum_a: assert property (vec_req_i && !vec_reset_i |=> vec_addr_o
        == 24'($past(vector_base_register_i) + {14'h0000, $past(vec_offset_i)}))
        else $error("vector address not base plus offset");
    reset_vec_a: assert property (vec_req_i && vec_reset_i |=> vec_addr_o == 24'h00_0000)
        else $error("reset vector address not fixed");
    block_size_a: assert property (int_sel_o || rsvd_hit_o |-> ext_addr_o[19:12] == 8'hFF)
        else $error("block decode wider than 4K");
    hold_sel_a: assert property (state_reg == rsd_pkg::RSD_ACT ##1 state_reg == rsd_pkg::RSD_ACT
        |-> $stable(int_sel_o) && $stable(ext_cycle_o) && $stable(ext_addr_o))
        else $error("selection changed inside a cycle");
    release_a: assert property (state_reg == rsd_pkg::RSD_ACT && addr_strobe_n_i
        |=> !int_sel_o && !ext_cycle_o ##1 state_reg == rsd_pkg::RSD_IDLE)
        else $error("selection not released after strobe");

    // main scenarios
    int_sel_c: cover property (start && impl && is_super ##1 int_sel_o);
    ext_from_blk_c: cover property (start && blk && !impl && !rsvd ##1 ext_cycle_o);
    deny_c: cover property (access_deny_o);
    reset_vec_c: cover property (vec_req_i && vec_reset_i ##1 vec_valid_o);
endmodule : rsd_space_decoder
`default_nettype wire

// File: verif/rsd_core_model.sv
// Purpose: core-side model that runs bus cycles and vector fetches
// Assumes: every signal changes just after a rising edge of mclk_i
// Notes: released lines show the inverse of the values driven for the cycle, except map_o, which keeps it
`timescale 1ns/1ns
`default_nettype none
module rsd_core_model (
    input wire logic mclk_i,
    output logic strobe_n_o,
    output logic [23:0] addr_o,
    output logic [15:0] wdata_o,
    output logic [2:0] fc_o,
    output logic map_o,
    output logic vreq_o,
    output logic vrst_o,
    output logic [9:0] voff_o,
    output logic [23:0] vbase_o
);
    // idle bus and idle vector port at time zero
    initial begin
        strobe_n_o = 1'b1;
        addr_o = 24'h00_0000;
        wdata_o = 16'h0000;
        fc_o = 3'h0;
        map_o = 1'b0;
        vreq_o = 1'b0;
        vrst_o = 1'b0;
        voff_o = 10'h000;
        vbase_o = 24'h00_0000;
    end

    // one bus cycle; wig inverts address, fc and map (not write data) while the strobe stays low
    task automatic bus_cycle(input logic [23:0] a, input logic [15:0] d, input logic [2:0] f,
                             input logic m, input int hold, input logic wig);
        @(posedge mclk_i);
        strobe_n_o <= 1'b0;
        addr_o <= a;
        wdata_o <= d;
        fc_o <= f;
        map_o <= m;
        repeat (hold) begin
            @(posedge mclk_i);
            if (wig) begin
                addr_o <= ~a;
                fc_o <= ~f;
                map_o <= ~m;
            end
        end
        @(posedge mclk_i);
        strobe_n_o <= 1'b1;
        addr_o <= ~a;
        wdata_o <= ~d;
        fc_o <= ~f;
        map_o <= m;
        @(posedge mclk_i);
    endtask : bus_cycle

    // one vector request per call, so calls in a row run back to back
    task automatic vec_fetch(input logic r, input logic [9:0] o, input logic [23:0] b);
        @(posedge mclk_i);
        vreq_o <= 1'b1;
        vrst_o <= r;
        voff_o <= o;
        vbase_o <= b;
    endtask : vec_fetch

    // release the vector port
    task automatic vec_stop();
        @(posedge mclk_i);
        vreq_o <= 1'b0;
        vrst_o <= ~vrst_o;
        voff_o <= ~voff_o;
        vbase_o <= ~vbase_o;
    endtask : vec_stop
endmodule : rsd_core_model
`default_nettype wire

// File: verif/test_register_space_decoder.sv
// Purpose: self-checking bench for the register space decoder
// Assumes: expectations queued by the driver, popped by a watcher
// Notes: random addresses come from an lfsr with a fixed start
`timescale 1ns/1ns
`default_nettype none
module test_register_space_decoder;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    wire logic sn, map, vreq, vrst;
    wire logic [23:0] addr, vbase;
    wire logic [15:0] wd;
    wire logic [2:0] fc;
    wire logic [9:0] voff;
    logic isel, ext, rsvd, deny, vval;
    logic [5:0] slot;
    logic [23:0] eaddr, vaddr;
    logic [15:0] edata;
    logic [2:0] efc, vfc;
    logic [52:0] bus_q[$];
    logic [26:0] vec_q[$];
    logic [52:0] cur = '1;
    logic busy_d = 1'b0;
    logic [31:0] seed = 32'h0001_7E32; // lfsr start, 97842
    int n_fail = 0;
    int num_checks = 0;

    always #10 mclk = ~mclk;

    rsd_core_model rsd_core_model_i (.mclk_i(mclk), .strobe_n_o(sn), .addr_o(addr),
        .wdata_o(wd), .fc_o(fc), .map_o(map), .vreq_o(vreq), .vrst_o(vrst), .voff_o(voff),
        .vbase_o(vbase));
    rsd_space_decoder rsd_space_decoder_i (.mclk_i(mclk), .reset_n_i(reset_n),
        .addr_strobe_n_i(sn), .addr_i(addr), .wdata_i(wd), .space_type_code_i(fc),
        .module_map_select_i(map), .vec_req_i(vreq), .vec_reset_i(vrst), .vec_offset_i(voff),
        .vector_base_register_i(vbase), .int_sel_o(isel), .ext_cycle_o(ext),
        .rsvd_hit_o(rsvd), .access_deny_o(deny), .reg_slot_o(slot), .ext_addr_o(eaddr),
        .ext_data_o(edata), .ext_fc_o(efc), .vec_valid_o(vval), .vec_addr_o(vaddr),
        .vec_fc_o(vfc));

    // compare and count
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // counts, verdict and end of run
    task automatic summarize();
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : summarize

    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nxt

    // expected flags {int, ext, rsvd, deny}, slot and captured copies
    function automatic logic [52:0] exp_bus(input logic [23:0] a, input logic [15:0] d,
                                            input logic [2:0] f, input logic m);
        logic [5:0] s;
        logic [3:0] fl;
        s = a[11:6];
        fl = 4'h4;
        if (a[23:20] == {m, 3'h7} && a[19:12] == 8'hFF) begin
            if (rsd_pkg::RSD_RSVD_MAP[s]) fl = 4'h2;
            else if (rsd_pkg::RSD_IMPL_MAP[s])
                fl = (rsd_pkg::RSD_SUPV_MAP[s] && !f[2]) ? 4'h1 : 4'h8;
        end
        return {fl, s, a, d, f};
    endfunction : exp_bus

    task automatic do_bus(input logic [23:0] a, input logic [15:0] d, input logic [2:0] f,
                          input logic m, input int hold, input logic wig);
        bus_q.push_back(exp_bus(a, d, f, m));
        rsd_core_model_i.bus_cycle(a, d, f, m, hold, wig);
    endtask : do_bus

    task automatic do_vec(input logic r, input logic [9:0] o, input logic [23:0] b);
        vec_q.push_back(r ? {rsd_pkg::RSD_RESET_VEC_ADDR, 3'h6} : {b + {14'h0, o}, 3'h5});
        rsd_core_model_i.vec_fetch(r, o, b);
    endtask : do_vec

    // watcher: pop a note on each new decision and each vector result
    always @(negedge mclk) begin
        if ({isel, ext, rsvd, deny} !== 4'h0) begin
            if (!busy_d) begin
                cur = (bus_q.size() > 0) ? bus_q.pop_front() : '1;
                chk({isel, ext, rsvd, deny, slot, eaddr, edata, efc}, cur);
            end else chk({isel, ext, rsvd, deny, slot, eaddr, edata, efc}, cur);
        end
        busy_d = ({isel, ext, rsvd, deny} !== 4'h0);
        if (vval === 1'b1) chk({vaddr, vfc}, (vec_q.size() > 0) ? vec_q.pop_front() : '1);
    end

    // main sequence
    initial begin
        repeat (4) @(posedge mclk);
        reset_n <= 1'b1;
        @(negedge mclk);
        chk({isel, ext, rsvd, deny, vval}, 64'h0);
        for (int m = 0; m < 2; m++) begin
            for (int i = 0; i < 8; i++) begin
                for (int f = 0; f < 8; f++) begin
                    do_bus({m[0], 3'h7, 8'hFF, 6'(i * 9 % 64), 6'h2A}, 16'hA5C3 ^ 16'(f),
                           3'(f), m[0], 1 + f % 3, f == 7);
                end
            end
        end
        do_bus(24'h7FEFFF, 16'h1234, 3'h5, 1'b0, 1, 1'b0);
        do_bus(24'hFFF040, 16'h5678, 3'h5, 1'b0, 2, 1'b0);
        for (int i = 0; i < 60; i++) begin
            seed = nxt(seed);
            do_bus({seed[25] ? {seed[23], 3'h7} : seed[23:20], seed[24] ? 8'hFF : seed[19:12],
                    seed[11:0]}, seed[31:16], seed[28:26], seed[29], 1 + seed[1:0], seed[30]);
        end
        do_vec(1'b0, 10'h3FF, 24'hFFFFF0);
        do_vec(1'b1, 10'h004, 24'h123400);
        for (int i = 0; i < 6; i++) begin
            seed = nxt(seed);
            do_vec(seed[0], seed[10:1], seed[31:8]);
        end
        rsd_core_model_i.vec_stop();
        for (int i = 0; i < 50 && (bus_q.size() + vec_q.size()) > 0; i++) @(posedge mclk);
        if ((bus_q.size() + vec_q.size()) > 0) n_fail++;
        summarize();
    end
endmodule : test_register_space_decoder
`default_nettype wire
